// ---- verilog/pcicfg_regs.v ----
// Purpose: PCI configuration register bank of the ethernet controller
// Assumes: config cycles decoded upstream into one-cycle rd/wr strobes
// Notes:   status flags are write-one-to-clear; hardware set wins
//
// Notes on behaviour
// - eeprom fields reload after every PCI reset release
// - card info pointer is read only
// - scratch byte 15:8 writable, rest reserved
// - marker register fixed, writes ignored
// - offset zero gives device and vendor codes
// - parity detected set on any i_parity_err; an address parity error does not set it
// - system error signalled set when SERR asserted
// - master abort received flag on master abort
// - target abort received flag on target abort
// - select timing reads 01, read only
// - data parity reported needs three conditions
// - fast back-to-back capable always reads one
// - new capabilities mirrors host config capability bit
// - address parity error drives SERR when enabled
// - parity response gates host status system error
// - no master cycles unless bus master enabled
// - memory decode only with memory space enable
// - io decode only with io space enable
// - only hardware reset restores defaults
// - byte, word and dword accesses by enables
`timescale 1ns/10ps
`default_nettype none
`include "pcicfg_consts.vh"
module pcicfg_regs #(
  parameter [31:0] MARKER_VAL = 32'h12345678, // arbitrary value
  parameter [7:0]  INT_PIN    = 8'h01,
  parameter [15:0] PM_CAPS    = 16'h0000
) (
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  input  wire        i_soft_rst,
  input  wire        i_cfg_rd,
  input  wire        i_cfg_wr,
  input  wire [7:0]  i_cfg_addr,
  input  wire [3:0]  i_cfg_be,
  input  wire [31:0] i_cfg_wdata,
  output reg  [31:0] o_cfg_rdata,
  output reg         o_cfg_ack,
  output reg         o_ee_load_req,
  input  wire        i_ee_valid,
  input  wire [31:0] i_ee_ident,
  input  wire [31:0] i_ee_subsys,
  input  wire [31:0] i_ee_cardinfo,
  input  wire [15:0] i_ee_lat_gnt,
  input  wire        i_cap_enable,
  input  wire        i_parity_err,
  input  wire        i_addr_parity_err,
  input  wire        i_perr_seen,
  input  wire        i_master_active,
  input  wire        i_master_abort,
  input  wire        i_target_abort,
  input  wire        i_master_req,
  input  wire        i_mem_hit,
  input  wire        i_io_hit,
  output wire        o_serr,
  output wire        o_host_syserr,
  output wire        o_master_req,
  output wire        o_mem_claim,
  output wire        o_io_claim,
  output wire        o_rom_enable
);

  reg  [31:0] ident_r;
  reg  [31:0] subsys_r;
  reg  [31:0] cardinfo_r;
  reg  [15:0] lat_gnt_r;
  reg         started_r;
  reg  [31:0] cmd_r;
  reg  [4:0]  stat_r;
  reg  [4:0]  stat_nxt;
  reg  [31:0] latency_r;
  reg  [31:0] iobase_r;
  reg  [31:0] membase_r;
  reg  [31:0] rombase_r;
  reg  [31:0] intline_r;
  reg  [31:0] scratch_r;
  reg  [31:0] rd_nxt;
  wire [4:0]  stat_set;
  wire [4:0]  stat_clr;
  wire        wr_cmd;

  // byte-lane merge of writable bits only
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0]  be;
    input [31:0] mask;
    reg   [31:0] lanes;
    begin
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
      merge = (old & ~lanes) | (wdat & lanes);
    end
  endfunction

  function hit;
    input [7:0] off;
    begin
      hit = (i_cfg_addr[7:2] == off[7:2]);
    end
  endfunction

  assign wr_cmd = i_cfg_wr & hit(`PCICFG_OFF_CMDSTAT);

  assign o_serr = cmd_r[`PCICFG_BIT_SERR_EN] & i_addr_parity_err;
  // parity errors reach the host system error only when response is on; parity detected still sets
  assign o_host_syserr = cmd_r[`PCICFG_BIT_PAR_EN] & i_parity_err;
  assign o_master_req = i_master_req & cmd_r[`PCICFG_BIT_MASTER_EN];
  assign o_mem_claim = i_mem_hit & cmd_r[`PCICFG_BIT_MEM_EN];
  assign o_io_claim = i_io_hit & cmd_r[`PCICFG_BIT_IO_EN];
  assign o_rom_enable = rombase_r[0] & cmd_r[`PCICFG_BIT_MEM_EN];

  // status order: perr_det, serr_sig, mabort, tabort, dperr_rep
  assign stat_set[4] = i_parity_err;
  assign stat_set[3] = o_serr;
  assign stat_set[2] = i_master_abort & i_master_active;
  assign stat_set[1] = i_target_abort & i_master_active;
  assign stat_set[0] = i_perr_seen & i_master_active &
                       cmd_r[`PCICFG_BIT_PAR_EN];
  assign stat_clr = (wr_cmd & i_cfg_be[3]) ?
                    {i_cfg_wdata[31:28], i_cfg_wdata[24]} : 5'h00;

  // a flag set by hardware in the clearing cycle survives the clear
  function flag_next;
    input old;
    input set;
    input clr;
    begin
      flag_next = set | (old & ~clr);
    end
  endfunction

  always @* begin
    stat_nxt[4] = flag_next(stat_r[4], stat_set[4], stat_clr[4]);
    stat_nxt[3] = flag_next(stat_r[3], stat_set[3], stat_clr[3]);
    stat_nxt[2] = flag_next(stat_r[2], stat_set[2], stat_clr[2]);
    stat_nxt[1] = flag_next(stat_r[1], stat_set[1], stat_clr[1]);
    stat_nxt[0] = flag_next(stat_r[0], stat_set[0], stat_clr[0]);
  end

  always @* begin
    rd_nxt = 32'h00000000;
    case ({i_cfg_addr[7:2], 2'b00})
      `PCICFG_OFF_IDENT: rd_nxt = ident_r;
      `PCICFG_OFF_CMDSTAT: begin
        rd_nxt = cmd_r;
        rd_nxt[`PCICFG_BIT_PERR_DET] = stat_r[4];
        rd_nxt[`PCICFG_BIT_SERR_SIG] = stat_r[3];
        rd_nxt[`PCICFG_BIT_MABORT] = stat_r[2];
        rd_nxt[`PCICFG_BIT_TABORT] = stat_r[1];
        rd_nxt[26:25] = `PCICFG_SEL_TIMING;
        rd_nxt[`PCICFG_BIT_DPERR_REP] = stat_r[0];
        rd_nxt[`PCICFG_BIT_FAST_B2B] = 1'b1;
        rd_nxt[`PCICFG_BIT_NEW_CAP] = i_cap_enable;
      end
      `PCICFG_OFF_CLASS: rd_nxt = `PCICFG_CLASS_VAL;
      `PCICFG_OFF_LATENCY: rd_nxt = latency_r;
      `PCICFG_OFF_IOBASE: rd_nxt = iobase_r | `PCICFG_IO_IND;
      `PCICFG_OFF_MEMBASE: rd_nxt = membase_r;
      `PCICFG_OFF_CARDINFO: rd_nxt = cardinfo_r;
      `PCICFG_OFF_SUBSYS: rd_nxt = subsys_r;
      `PCICFG_OFF_ROMBASE: rd_nxt = rombase_r;
      `PCICFG_OFF_CAPPTR: rd_nxt = {24'h000000, `PCICFG_CAPPTR_VAL};
      `PCICFG_OFF_INTLINE: rd_nxt = {lat_gnt_r, INT_PIN, intline_r[7:0]};
      `PCICFG_OFF_SCRATCH: rd_nxt = scratch_r;
      `PCICFG_OFF_MARKER: rd_nxt = MARKER_VAL;
      `PCICFG_OFF_PMCAP: rd_nxt = {PM_CAPS, 8'h00, `PCICFG_PM_CAP_ID};
      default: rd_nxt = `PCICFG_DW_RST;
    endcase
  end

  // one write strobe per writable register
  wire        wr_latency;
  wire        wr_iobase;
  wire        wr_membase;
  wire        wr_rombase;
  wire        wr_intline;
  wire        wr_scratch;
  wire        cfg_access;
  reg  [31:0] cmd_nxt;
  reg  [31:0] latency_nxt;
  reg  [31:0] iobase_nxt;
  reg  [31:0] membase_nxt;
  reg  [31:0] rombase_nxt;
  reg  [31:0] intline_nxt;
  reg  [31:0] scratch_nxt;
  reg  [31:0] rdata_nxt;
  reg         ack_nxt;
  reg         load_req_nxt;

  assign wr_latency = i_cfg_wr & hit(`PCICFG_OFF_LATENCY);
  assign wr_iobase  = i_cfg_wr & hit(`PCICFG_OFF_IOBASE);
  assign wr_membase = i_cfg_wr & hit(`PCICFG_OFF_MEMBASE);
  assign wr_rombase = i_cfg_wr & hit(`PCICFG_OFF_ROMBASE);
  assign wr_intline = i_cfg_wr & hit(`PCICFG_OFF_INTLINE);
  assign wr_scratch = i_cfg_wr & hit(`PCICFG_OFF_SCRATCH);
  assign cfg_access = i_cfg_rd | i_cfg_wr;

  // read-only and reserved bits are masked out of every merge
  always @* begin
    cmd_nxt     = cmd_r;
    latency_nxt = latency_r;
    iobase_nxt  = iobase_r;
    membase_nxt = membase_r;
    rombase_nxt = rombase_r;
    intline_nxt = intline_r;
    scratch_nxt = scratch_r;
    if (wr_cmd) begin
      cmd_nxt = merge(cmd_r, i_cfg_wdata, i_cfg_be, `PCICFG_CMD_MASK);
    end
    if (wr_latency) begin
      latency_nxt = merge(latency_r, i_cfg_wdata, i_cfg_be, `PCICFG_LATENCY_MASK);
    end
    if (wr_iobase) begin
      iobase_nxt = merge(iobase_r, i_cfg_wdata, i_cfg_be, `PCICFG_IOBASE_MASK);
    end
    if (wr_membase) begin
      membase_nxt = merge(membase_r, i_cfg_wdata, i_cfg_be, `PCICFG_MEMBASE_MASK);
    end
    if (wr_rombase) begin
      rombase_nxt = merge(rombase_r, i_cfg_wdata, i_cfg_be, `PCICFG_ROMBASE_MASK);
    end
    if (wr_intline) begin
      intline_nxt = merge(intline_r, i_cfg_wdata, i_cfg_be, `PCICFG_INTLINE_MASK);
    end
    if (wr_scratch) begin
      scratch_nxt = merge(scratch_r, i_cfg_wdata, i_cfg_be, `PCICFG_SCRATCH_MASK);
    end
  end

  // the read path only moves on a read, so stale data stays put
  always @* begin
    ack_nxt      = cfg_access;
    rdata_nxt    = o_cfg_rdata;
    load_req_nxt = ~started_r;
    if (i_cfg_rd) begin
      rdata_nxt = rd_nxt;
    end
  end

  // i_soft_rst is deliberately unused: software reset keeps this bank
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      started_r     <= 1'b0;
      o_ee_load_req <= 1'b0;
    end else begin
      started_r     <= 1'b1;
      o_ee_load_req <= load_req_nxt;
    end
  end

  // identifiers read zero until the reader answers, so a lost load shows
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ident_r <= `PCICFG_DW_RST;
    end else if (i_ee_valid) begin
      ident_r <= i_ee_ident;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      subsys_r <= `PCICFG_DW_RST;
    end else if (i_ee_valid) begin
      subsys_r <= i_ee_subsys;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cardinfo_r <= `PCICFG_DW_RST;
    end else if (i_ee_valid) begin
      cardinfo_r <= i_ee_cardinfo;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      lat_gnt_r <= `PCICFG_HW_RST;
    end else if (i_ee_valid) begin
      lat_gnt_r <= i_ee_lat_gnt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      stat_r <= `PCICFG_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cmd_r <= `PCICFG_DW_RST;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      latency_r <= `PCICFG_DW_RST;
    end else begin
      latency_r <= latency_nxt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      iobase_r <= `PCICFG_IOBASE_RST;
    end else begin
      iobase_r <= iobase_nxt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      membase_r <= `PCICFG_DW_RST;
    end else begin
      membase_r <= membase_nxt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rombase_r <= `PCICFG_DW_RST;
    end else begin
      rombase_r <= rombase_nxt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      intline_r <= `PCICFG_DW_RST;
    end else begin
      intline_r <= intline_nxt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scratch_r <= `PCICFG_DW_RST;
    end else begin
      scratch_r <= scratch_nxt;
    end
  end

  // every access is answered one cycle later, mapped or not
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_cfg_ack   <= 1'b0;
      o_cfg_rdata <= `PCICFG_DW_RST;
    end else begin
      o_cfg_ack   <= ack_nxt;
      o_cfg_rdata <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/pcicfg_consts.vh ----
// Purpose: constants of the configuration register bank
// Assumes: included by pcicfg_regs.v only
// Notes:   offsets are byte addresses of aligned dwords
`ifndef PCICFG_CONSTS_VH
`define PCICFG_CONSTS_VH
`define PCICFG_OFF_IDENT     8'h00
`define PCICFG_OFF_CMDSTAT   8'h04
`define PCICFG_OFF_CLASS     8'h08
`define PCICFG_OFF_LATENCY   8'h0c
`define PCICFG_OFF_IOBASE    8'h10
`define PCICFG_OFF_MEMBASE   8'h14
`define PCICFG_OFF_CARDINFO  8'h28
`define PCICFG_OFF_SUBSYS    8'h2c
`define PCICFG_OFF_ROMBASE   8'h30
`define PCICFG_OFF_CAPPTR    8'h34
`define PCICFG_OFF_INTLINE   8'h3c
`define PCICFG_OFF_SCRATCH   8'h40
`define PCICFG_OFF_MARKER    8'h80
`define PCICFG_OFF_PMCAP     8'hc0
`define PCICFG_OFF_PMCTL     8'hc4
`define PCICFG_BIT_PERR_DET  31
`define PCICFG_BIT_SERR_SIG  30
`define PCICFG_BIT_MABORT    29
`define PCICFG_BIT_TABORT    28
`define PCICFG_BIT_DPERR_REP 24
`define PCICFG_BIT_FAST_B2B  23
`define PCICFG_BIT_NEW_CAP   20
`define PCICFG_BIT_SERR_EN   8
`define PCICFG_BIT_PAR_EN    6
`define PCICFG_BIT_MASTER_EN 2
`define PCICFG_BIT_MEM_EN    1
`define PCICFG_BIT_IO_EN     0
`define PCICFG_SEL_TIMING    2'h1
`define PCICFG_CLASS_VAL     32'h02000011
`define PCICFG_CAPPTR_VAL    8'hc0
`define PCICFG_PM_CAP_ID     8'h01
`define PCICFG_IOBASE_MASK   32'hffffff00
`define PCICFG_MEMBASE_MASK  32'hfffffc00
`define PCICFG_ROMBASE_MASK  32'hfffe0001
`define PCICFG_LATENCY_MASK  32'h0000ffff
`define PCICFG_INTLINE_MASK  32'h000000ff
`define PCICFG_SCRATCH_MASK  32'h0000ff00
`define PCICFG_CMD_MASK      32'h00000147
`define PCICFG_IOBASE_RST    32'h00000000
`define PCICFG_IO_IND        32'h00000001
`define PCICFG_DW_RST        32'h00000000
`define PCICFG_HW_RST        16'h0000
`define PCICFG_STAT_RST      5'h00
`endif

// ---- sim/pcicfg_regs_chk.sv ----
// Purpose: port assertions for pcicfg_regs
// Assumes: enables live inside the bank, so claims are tied to their causes
// Notes:   read data is sampled one edge after the strobe
`timescale 1ns/10ps
`default_nettype none
module pcicfg_regs_chk #(
  parameter [31:0] MARKER_VAL = 32'h12345678
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_cfg_rd,
  input wire logic        i_cfg_wr,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_cfg_ack,
  input wire logic        o_ee_load_req,
  input wire logic        i_addr_parity_err,
  input wire logic        o_serr,
  input wire logic        i_parity_err,
  input wire logic        o_host_syserr,
  input wire logic        i_master_req,
  input wire logic        o_master_req,
  input wire logic        i_mem_hit,
  input wire logic        o_mem_claim,
  input wire logic        i_io_hit,
  input wire logic        o_io_claim
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_load_pulse;
    o_ee_load_req ##1 !o_ee_load_req;
  endsequence
  sequence s_rd(logic [5:0] dw);
    i_cfg_rd && i_cfg_addr[7:2] == dw;
  endsequence
  AST_LOAD: assert property ($rose(i_rst_n) |=> s_load_pulse)
    else $error("eeprom load request not one cycle");
  AST_ACK: assert property ((i_cfg_rd || i_cfg_wr) |=> o_cfg_ack)
    else $error("access not acknowledged");
  AST_HOLD: assert property (!i_cfg_rd |=> $stable(o_cfg_rdata))
    else $error("read data moved without a read");
  AST_SEL: assert property (s_rd(6'h01) |=> {o_cfg_rdata[26:25], o_cfg_rdata[23]} == 3'b011)
    else $error("fixed status bits wrong");
  AST_MARK: assert property (s_rd(6'h20) |=> o_cfg_rdata == MARKER_VAL)
    else $error("marker value wrong");
  AST_SERR: assert property (o_serr |-> i_addr_parity_err)
    else $error("serr without address parity error");
  AST_SYS: assert property (o_host_syserr |-> i_parity_err)
    else $error("host system error without parity error");
  AST_MST: assert property (o_master_req |-> i_master_req)
    else $error("master request without cause");
  AST_MEM: assert property (o_mem_claim |-> i_mem_hit)
    else $error("memory claim without hit");
  AST_IO: assert property (o_io_claim |-> i_io_hit)
    else $error("io claim without hit");
endmodule
bind pcicfg_regs pcicfg_regs_chk #(.MARKER_VAL(MARKER_VAL)) chk (.*);
`default_nettype wire

// ---- sim/pcicfg_host_model.sv ----
// Purpose: host bridge issuing configuration cycles
// Assumes: answer comes on the same edge that takes the strobe, one edge after it is driven
// Notes:   released address and data lines carry inverted junk so stale values never match
`timescale 1ns/10ps
`default_nettype none
module pcicfg_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  output var  logic        o_rd,
  output var  logic        o_wr,
  output var  logic [7:0]  o_addr,
  output var  logic [3:0]  o_be,
  output var  logic [31:0] o_wdata
);
  int hangs = 0;
  initial begin
    {o_rd, o_wr, o_addr, o_be, o_wdata} = '0;
  end
  // one dword access per call, lanes chosen by byte enables
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_sys_clk);
    o_rd <= !w;
    o_wr <= w;
    o_addr <= a;
    o_be <= b;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
    if (i_ack !== 1'b1) hangs++;
    q = i_rdata;
  endtask
endmodule
`default_nettype wire

// ---- sim/test_pcicfg_regs.sv ----
// Purpose: register-level test of pcicfg_regs
// Assumes: cap enable high until after the second hardware reset
// Notes:   eeprom reader is a one-cycle echo of the load request
`timescale 1ns/10ps
`default_nettype none
module test_pcicfg_regs;
  localparam [31:0] MK = 32'h12345678;
  logic i_sys_clk, i_rst_n, i_soft_rst, i_cfg_rd, i_cfg_wr, o_cfg_ack, o_ee_load_req;
  logic i_ee_valid, i_cap_enable, i_parity_err, i_addr_parity_err, i_perr_seen;
  logic i_master_active, i_master_abort, i_target_abort, i_master_req, i_mem_hit;
  logic i_io_hit, o_serr, o_host_syserr, o_master_req, o_mem_claim, o_io_claim, o_rom_enable;
  logic [7:0]  i_cfg_addr;
  logic [3:0]  i_cfg_be;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, i_ee_ident, q;
  logic [1:0]  s;
  wire  [31:0] i_ee_subsys   = ~i_ee_ident;
  wire  [31:0] i_ee_cardinfo = i_ee_ident ^ 32'h0f0f0f0f;
  wire  [15:0] i_ee_lat_gnt  = i_ee_ident[15:0];
  int          err_total = 0;
  int          samples_checked = 0;
  `define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
  pcicfg_regs #(.MARKER_VAL(MK)) uut (.*);
  pcicfg_host_model host (.i_sys_clk(i_sys_clk), .i_ack(o_cfg_ack), .i_rdata(o_cfg_rdata),
    .o_rd(i_cfg_rd), .o_wr(i_cfg_wr), .o_addr(i_cfg_addr), .o_be(i_cfg_be),
    .o_wdata(i_cfg_wdata));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) i_ee_valid <= o_ee_load_req;
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    host.xfer(1'b1, a, b, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 4'hf, 32'h0, q);
    `CHK(q, e)
  endtask
  // drive {perr, aperr, seen, active, mabort, tabort} for one cycle
  task automatic ev(input logic [5:0] v);
    @(posedge i_sys_clk);
    {i_parity_err, i_addr_parity_err, i_perr_seen, i_master_active, i_master_abort,
     i_target_abort} <= v;
    #1 s = {o_serr, o_host_syserr};
    @(posedge i_sys_clk);
    {i_parity_err, i_addr_parity_err, i_perr_seen, i_master_active, i_master_abort,
     i_target_abort} <= 6'h0;
  endtask
  task automatic hw_reset(input logic [31:0] id);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    i_ee_ident <= id;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
  endtask
  task summarize;
    err_total += host.hangs;
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {i_soft_rst, i_ee_valid, i_parity_err, i_addr_parity_err, i_perr_seen} = '0;
    {i_master_active, i_master_abort, i_target_abort} = '0;
    {i_master_req, i_mem_hit, i_io_hit, i_cap_enable, i_rst_n} = 5'h1e;
    i_ee_ident = 32'h0;
    hw_reset(32'h1234abcd); // arbitrary identity value
    rc(8'h00, 32'h1234abcd);
    wr(8'h00, 4'hf, 32'h0);
    rc(8'h00, 32'h1234abcd);
    wr(8'h28, 4'hf, 32'hffffffff);
    rc(8'h28, 32'h1d3ba4c2);
    rc(8'h2c, 32'hedcb5432);
    rc(8'h3c, 32'habcd0100);
    rc(8'h10, 32'h00000001);
    rc(8'h34, 32'h000000c0);
    `CHK({o_master_req, o_mem_claim, o_io_claim, o_rom_enable}, 4'h0)
    rc(8'h04, 32'h02900000);
    wr(8'h40, 4'hf, 32'hffffffff);
    rc(8'h40, 32'h0000ff00);
    wr(8'h40, 4'h2, 32'h0000a5a5);
    wr(8'h40, 4'hd, 32'h0);
    rc(8'h40, 32'h0000a500);
    wr(8'h80, 4'hf, 32'h0);
    rc(8'h80, MK);
    rc(8'h18, 32'h0);
    wr(8'h04, 4'h3, 32'hffffffff);
    rc(8'h04, 32'h02900147);
    `CHK({o_master_req, o_mem_claim, o_io_claim}, 3'b111)
    wr(8'h30, 4'hf, 32'hffffffff);
    rc(8'h30, 32'hfffe0001);
    `CHK(o_rom_enable, 1'b1)
    ev(6'h3f);
    `CHK(s, 2'b11)
    rc(8'h04, 32'hf3900147);
    wr(8'h04, 4'h8, 32'hf1000000);
    rc(8'h04, 32'h02900147);
    wr(8'h04, 4'h3, 32'h00000007);
    ev(6'h34);
    `CHK(s, 2'b00)
    rc(8'h04, 32'h82900007);
    @(posedge i_sys_clk) i_soft_rst <= 1'b1;
    @(posedge i_sys_clk) i_soft_rst <= 1'b0;
    rc(8'h40, 32'h0000a500);
    hw_reset(32'h4321dcba); // arbitrary identity value
    i_cap_enable <= 1'b0;
    rc(8'h00, 32'h4321dcba);
    rc(8'h40, 32'h0);
    `CHK(o_rom_enable, 1'b0)
    rc(8'h04, 32'h02800000);
    summarize;
  end
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    err_total++;
    summarize;
  end
endmodule
`default_nettype wire
